// File: logic/cs_ocp_consts.svh
`ifndef CS_OCP_CONSTS_SVH
`define CS_OCP_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_OCP_THR_A      16'hFE18
`define IDX_OCP_THR_B      16'hFE19
`define IDX_SENSE_CFG_A    16'hFE1A
`define IDX_SENSE_CFG_B    16'hFE1B
`define IDX_STATUS         16'hFE30

// Reset values
`define RST_OCP_THR        8'hFF
`define RST_SENSE_CFG      8'h00

// Sense/debounce/light-load field positions
`define CFG_HIGH_SIDE_BIT  7
`define CFG_DEB_MSB        6
`define CFG_DEB_LSB        5
`define CFG_BLANK_BIT      4
`define CFG_LL_MSB         3
`define CFG_LL_LSB         0

// Overcurrent threshold that disables the flag
`define OCP_THR_OFF        8'hFF

// Light-load scaling: code step and exit hysteresis in reading counts
`define LL_STEP_SHIFT      6
`define LL_HYST_COUNTS     13'h060

// Timing
`define CLK_FREQ_HZ        125000000
`define DEB_SHORT_MS       20
`define DEB_MID_MS         200
`define DEB_LONG_S         1

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// File: logic/cs_ocp_pkg.sv
`default_nettype none
package cs_ocp_pkg;

	typedef logic [11:0] reading_t;
	typedef logic [7:0]  reg8_t;
	typedef logic [26:0] deb_cnt_t;

	typedef enum logic [1:0] {
		DEB_NONE,
		DEB_SHORT,
		DEB_MID,
		DEB_LONG
	} deb_sel_t;

endpackage : cs_ocp_pkg
`default_nettype wire

// File: logic/current_sense_ocp_lightload_detect.sv
// Functional notes
// - Bit 7 of each channel's setup register picks low-side (0) or high-side (1) sensing.
// - A 2-bit field selects overcurrent debounce of none, 20 ms, 200 ms or 1 s.
// - A setup bit, when 1, blanks the light-load flag during that channel's soft start.
// - A reading below the light-load threshold sets the flag and enters light-load mode.
// - Each light-load threshold code step equals 64 counts of the 12-bit reading.
// - Light-load mode is left once the reading reaches the entry threshold plus 96, or at once when the code is zero.
// - A light-load threshold code of zero keeps that channel's light-load flag cleared.
// - The setup register for channel A sits at 0xFE1A and for channel B at 0xFE1B.
// - The raw overcurrent condition is the reading's upper eight bits above the threshold.
// - An overcurrent threshold of all ones keeps that channel's overcurrent flag cleared.
`timescale 1ns/1ps
`default_nettype none
`include "cs_ocp_consts.svh"

module current_sense_ocp_lightload_detect #(
	parameter int unsigned DEB_SHORT_CYC = `DEB_SHORT_MS * (`CLK_FREQ_HZ / 1000),
	parameter int unsigned DEB_MID_CYC   = `DEB_MID_MS * (`CLK_FREQ_HZ / 1000),
	parameter int unsigned DEB_LONG_CYC  = `DEB_LONG_S * `CLK_FREQ_HZ
) (
	input  wire logic                    sys_clk,
	input  wire logic                    sys_rst,
	// AXI4-Lite slave
	input  wire logic [17:0]             s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [17:0]             s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// Current-sense readings and soft-start status
	input  wire cs_ocp_pkg::reading_t    chan_a_current_input,
	input  wire cs_ocp_pkg::reading_t    chan_b_current_input,
	input  wire logic                    chan_a_soft_start,
	input  wire logic                    chan_b_soft_start,
	// Toward PWM and fault handling
	output logic                         chan_a_high_side_sense,
	output logic                         chan_b_high_side_sense,
	output logic                         chan_a_overcurrent_flag,
	output logic                         chan_b_overcurrent_flag,
	output logic                         chan_a_light_load_flag,
	output logic                         chan_b_light_load_flag,
	output logic                         chan_a_light_load_mode,
	output logic                         chan_b_light_load_mode
);

	function automatic cs_ocp_pkg::deb_cnt_t deb_limit(input logic [1:0] sel);
		cs_ocp_pkg::deb_cnt_t lim;
		lim = '0;
		unique case (cs_ocp_pkg::deb_sel_t'(sel))
			cs_ocp_pkg::DEB_NONE:  lim = '0;
			cs_ocp_pkg::DEB_SHORT: lim = 27'(DEB_SHORT_CYC - 1);
			cs_ocp_pkg::DEB_MID:   lim = 27'(DEB_MID_CYC - 1);
			cs_ocp_pkg::DEB_LONG:  lim = 27'(DEB_LONG_CYC - 1);
		endcase
		return lim;
	endfunction : deb_limit

	function automatic logic [12:0] ll_enter(input logic [3:0] code);
		return 13'({code, {`LL_STEP_SHIFT{1'b0}}});
	endfunction : ll_enter

	// Register storage, index 0 = channel A, 1 = channel B
	cs_ocp_pkg::reg8_t    ocp_thr_r   [2];
	cs_ocp_pkg::reg8_t    sense_cfg_r [2];
	cs_ocp_pkg::deb_cnt_t deb_cnt_r   [2];
	logic [1:0]           ocp_flag_r;
	logic [1:0]           ll_mode_r;
	logic [1:0]           ll_flag_r;

	// Bus response registers
	logic        awready_r;
	logic        wready_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        arready_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;

	// Write and read path decode
	wire logic [15:0] aw_idx   = s_axi_awaddr[17:2];
	wire logic [15:0] ar_idx   = s_axi_araddr[17:2];
	wire logic        wr_fire  = awready_r & s_axi_awvalid & wready_r & s_axi_wvalid;
	wire logic        wr_lane0 = wr_fire & s_axi_wstrb[0];
	wire logic        aw_hit   = (aw_idx == `IDX_OCP_THR_A) | (aw_idx == `IDX_OCP_THR_B)
	                           | (aw_idx == `IDX_SENSE_CFG_A) | (aw_idx == `IDX_SENSE_CFG_B)
	                           | (aw_idx == `IDX_STATUS);
	wire logic        wr_start = s_axi_awvalid & s_axi_wvalid & ~awready_r & ~bvalid_r;
	wire logic        rd_fire  = arready_r & s_axi_arvalid;
	wire logic        rd_start = s_axi_arvalid & ~arready_r & ~rvalid_r;

	wire logic [1:0] wr_ocp = {wr_lane0 & (aw_idx == `IDX_OCP_THR_B),
	                           wr_lane0 & (aw_idx == `IDX_OCP_THR_A)};
	wire logic [1:0] wr_cfg = {wr_lane0 & (aw_idx == `IDX_SENSE_CFG_B),
	                           wr_lane0 & (aw_idx == `IDX_SENSE_CFG_A)};

	wire cs_ocp_pkg::reading_t reading [2];
	wire logic                 soft_start [2];
	assign reading[0]    = chan_a_current_input;
	assign reading[1]    = chan_b_current_input;
	assign soft_start[0] = chan_a_soft_start;
	assign soft_start[1] = chan_b_soft_start;

	logic [1:0] ocp_raw;

	// Read data selection
	wire logic [7:0] status_byte = {ocp_raw, ll_mode_r, ll_flag_r, ocp_flag_r};
	wire logic       ar_hit;
	wire logic [7:0] rd_byte;
	assign ar_hit  = (ar_idx == `IDX_OCP_THR_A) | (ar_idx == `IDX_OCP_THR_B)
	               | (ar_idx == `IDX_SENSE_CFG_A) | (ar_idx == `IDX_SENSE_CFG_B)
	               | (ar_idx == `IDX_STATUS);
	assign rd_byte = (ar_idx == `IDX_OCP_THR_A)   ? ocp_thr_r[0]   :
	                 (ar_idx == `IDX_OCP_THR_B)   ? ocp_thr_r[1]   :
	                 (ar_idx == `IDX_SENSE_CFG_A) ? sense_cfg_r[0] :
	                 (ar_idx == `IDX_SENSE_CFG_B) ? sense_cfg_r[1] :
	                 (ar_idx == `IDX_STATUS)      ? status_byte    : 8'h00;

	// Write channel: address and data taken together, one write in flight
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `RESP_OKAY;
		end
		else
		begin
			awready_r <= wr_start;
			wready_r  <= wr_start;
			if (wr_fire)
			begin
				bvalid_r <= 1'b1;
				// Status is read-only, so a write there still answers OKAY and is dropped
				bresp_r  <= aw_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready)
			begin
				bvalid_r <= 1'b0;
			end
		end
	end

	// Read channel
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= `RESP_OKAY;
		end
		else
		begin
			arready_r <= rd_start;
			if (rd_fire)
			begin
				rvalid_r <= 1'b1;
				rdata_r  <= {24'h00_0000, rd_byte};
				rresp_r  <= ar_hit ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_rready)
			begin
				rvalid_r <= 1'b0;
			end
		end
	end

	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		wire logic [3:0]  ll_code  = sense_cfg_r[ch][`CFG_LL_MSB:`CFG_LL_LSB];
		wire logic [12:0] ll_in    = ll_enter(ll_code);
		wire logic [12:0] ll_out   = ll_in + `LL_HYST_COUNTS;
		wire logic [12:0] rd_wide  = {1'b0, reading[ch]};
		wire logic        ll_off   = (ll_code == 4'h0);
		wire logic        ll_below = rd_wide < ll_in;
		wire logic        ll_above = rd_wide >= ll_out;
		wire logic        blank    = sense_cfg_r[ch][`CFG_BLANK_BIT] & soft_start[ch];
		wire logic        mode_nxt = ll_off ? 1'b0 :
		                             ll_mode_r[ch] ? ~ll_above : ll_below;
		wire cs_ocp_pkg::deb_cnt_t limit =
		                 deb_limit(sense_cfg_r[ch][`CFG_DEB_MSB:`CFG_DEB_LSB]);

		// Upper eight of twelve bits must exceed the threshold register's byte
		assign ocp_raw[ch] = (ocp_thr_r[ch] != `OCP_THR_OFF)
		                   & (reading[ch][11:4] > ocp_thr_r[ch]);

		always_ff @(posedge sys_clk)
		begin
			if (sys_rst)
			begin
				ocp_thr_r[ch]   <= `RST_OCP_THR;
				sense_cfg_r[ch] <= `RST_SENSE_CFG;
			end
			else
			begin
				if (wr_ocp[ch])
				begin
					ocp_thr_r[ch] <= s_axi_wdata[7:0];
				end
				if (wr_cfg[ch])
				begin
					sense_cfg_r[ch] <= s_axi_wdata[7:0];
				end
			end
		end

		// Timer restarts on any drop; a shorter limit written mid-count takes effect at once
		always_ff @(posedge sys_clk)
		begin
			if (sys_rst)
			begin
				deb_cnt_r[ch]  <= '0;
				ocp_flag_r[ch] <= 1'b0;
			end
			else if (!ocp_raw[ch])
			begin
				deb_cnt_r[ch]  <= '0;
				ocp_flag_r[ch] <= 1'b0;
			end
			else if (deb_cnt_r[ch] >= limit)
			begin
				ocp_flag_r[ch] <= 1'b1;
			end
			else
			begin
				deb_cnt_r[ch] <= deb_cnt_r[ch] + 27'h000_0001;
			end
		end

		// Blanking hides the flag only; the mode itself keeps tracking the load
		always_ff @(posedge sys_clk)
		begin
			if (sys_rst)
			begin
				ll_mode_r[ch] <= 1'b0;
				ll_flag_r[ch] <= 1'b0;
			end
			else
			begin
				ll_mode_r[ch] <= mode_nxt;
				ll_flag_r[ch] <= mode_nxt & ~blank;
			end
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

	assign chan_a_high_side_sense  = sense_cfg_r[0][`CFG_HIGH_SIDE_BIT];
	assign chan_b_high_side_sense  = sense_cfg_r[1][`CFG_HIGH_SIDE_BIT];
	assign chan_a_overcurrent_flag = ocp_flag_r[0];
	assign chan_b_overcurrent_flag = ocp_flag_r[1];
	assign chan_a_light_load_flag  = ll_flag_r[0];
	assign chan_b_light_load_flag  = ll_flag_r[1];
	assign chan_a_light_load_mode  = ll_mode_r[0];
	assign chan_b_light_load_mode  = ll_mode_r[1];

endmodule : current_sense_ocp_lightload_detect
`default_nettype wire

// File: bench/cs_ocp_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_ocp_consts.svh"
module cs_ocp_asserts (
	input wire logic                 sys_clk,
	input wire logic                 sys_rst,
	input wire logic [17:0]          s_axi_awaddr,
	input wire logic                 s_axi_awvalid,
	input wire logic                 s_axi_awready,
	input wire logic [31:0]          s_axi_wdata,
	input wire logic [3:0]           s_axi_wstrb,
	input wire logic                 s_axi_wvalid,
	input wire logic                 s_axi_wready,
	input wire logic [1:0]           s_axi_bresp,
	input wire logic                 s_axi_bvalid,
	input wire logic                 s_axi_bready,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic [31:0]          s_axi_rdata,
	input wire logic                 s_axi_rvalid,
	input wire logic                 s_axi_rready,
	input wire cs_ocp_pkg::reading_t chan_a_current_input,
	input wire logic                 chan_a_high_side_sense,
	input wire logic                 chan_a_overcurrent_flag,
	input wire logic                 chan_a_light_load_flag,
	input wire logic                 chan_a_light_load_mode
);
	wire [15:0] widx = s_axi_awaddr[17:2];
	wire        mapped = (widx >= `IDX_OCP_THR_A && widx <= `IDX_SENSE_CFG_B)
		|| widx == `IDX_STATUS;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_answer_a: assert property (wr_take |=> s_axi_bvalid && !s_axi_awready
		&& s_axi_bresp == ($past(mapped) ? 2'h0 : 2'h2)) else $error("write answer wrong");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
		&& $stable(s_axi_bresp)) else $error("write response dropped");
	aw_pair_a: assert property (s_axi_awready |-> s_axi_wready ##1 !s_axi_awready)
		else $error("address and data ready apart");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready
		&& s_axi_rdata[31:8] == 24'h0) else $error("read answer wrong");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read data dropped");
	side_sel_a: assert property (wr_take ##0 (widx == `IDX_SENSE_CFG_A
		&& s_axi_wstrb[0]) |-> ##2 chan_a_high_side_sense == $past(s_axi_wdata[7], 2))
		else $error("sense side not taken");
	ocp_cause_a: assert property (chan_a_overcurrent_flag
		|-> $past(chan_a_current_input[11:4]) != 8'h00) else $error("overcurrent without cause");
	ll_gate_a: assert property (chan_a_light_load_flag |-> chan_a_light_load_mode)
		else $error("light-load flag without mode");
	ll_enter_a: assert property ($rose(chan_a_light_load_mode)
		|-> $past(chan_a_current_input) < 12'h3C0) else $error("light-load entry too high");
endmodule : cs_ocp_asserts
bind current_sense_ocp_lightload_detect cs_ocp_asserts i_chk (.*);
`default_nettype wire

// File: bench/sense_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module sense_source_model (
	input wire cs_ocp_pkg::reading_t lvl_a,
	input wire cs_ocp_pkg::reading_t lvl_b,
	output wire cs_ocp_pkg::reading_t chan_a_current_input,
	output wire cs_ocp_pkg::reading_t chan_b_current_input
);
	// Converter result follows the commanded load at once
	assign chan_a_current_input = lvl_a;
	assign chan_b_current_input = lvl_b;
endmodule : sense_source_model
`default_nettype wire

// File: bench/current_sense_ocp_lightload_detect_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cs_ocp_consts.svh"
module current_sense_ocp_lightload_detect_tb;
	logic sys_clk = 0, sys_rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, chan_a_soft_start = 0, chan_b_soft_start = 0;
	logic [17:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 0;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic chan_a_high_side_sense, chan_b_high_side_sense, chan_a_overcurrent_flag;
	logic chan_b_overcurrent_flag, chan_a_light_load_flag, chan_b_light_load_flag;
	logic chan_a_light_load_mode, chan_b_light_load_mode;
	cs_ocp_pkg::reading_t lvl_a = 0, lvl_b = 0, chan_a_current_input, chan_b_current_input;
	logic [33:0] notes[$];
	int err_total = 0, tests_run = 0, seed = 32'h1911, c, v, m;
	localparam int LIM[4] = '{1, 5, 10, 20};
	localparam int VALS[5] = '{63, 159, 160, 64, 63};
	always #4 sys_clk = ~sys_clk;
	// Short debounce counts keep the run brief
	current_sense_ocp_lightload_detect #(.DEB_SHORT_CYC(5), .DEB_MID_CYC(10),
		.DEB_LONG_CYC(20)) i_dut (.*);
	sense_source_model i_src (.*);
	task chk(input logic [33:0] seen, input logic [33:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tally_and_finish;
		$display("mismatches %0d of %0d checks", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task hs(input int k);
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (!(k == 1 ? s_axi_awready && s_axi_wready : k == 2 ? s_axi_bvalid
			: k == 3 ? s_axi_arready : s_axi_rvalid) && n < 40);
		if (n >= 40)
		begin
			err_total++;
			tally_and_finish();
		end
	endtask : hs
	task wr(input logic [15:0] idx, input logic [7:0] d, input logic [3:0] st, input logic [1:0] rs);
		@(posedge sys_clk);
		notes.push_back({rs, 32'h0});
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_wdata <= {24'hA5A5A5, d};
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		hs(1);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		// Late ready exercises a standing response
		repeat (2) @(posedge sys_clk);
		s_axi_bready <= 1;
		hs(2);
		s_axi_bready <= 0;
	endtask : wr
	task rd(input logic [15:0] idx, input logic [1:0] rs, input logic [7:0] d);
		@(posedge sys_clk);
		notes.push_back({rs, 24'h0, d});
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1;
		hs(3);
		s_axi_arvalid <= 0;
		repeat (2) @(posedge sys_clk);
		s_axi_rready <= 1;
		hs(4);
		s_axi_rready <= 0;
	endtask : rd
	always @(posedge sys_clk)
		if (s_axi_rvalid && s_axi_rready || s_axi_bvalid && s_axi_bready)
			chk(s_axi_rvalid ? {s_axi_rresp, s_axi_rdata} : {s_axi_bresp, 32'h0},
				notes.pop_front());
	initial
	begin
		repeat (3) @(posedge sys_clk);
		sys_rst <= 0;
		rd(`IDX_OCP_THR_A, 0, 8'hFF);
		rd(`IDX_SENSE_CFG_B, 0, 8'h00);
		wr(16'hFE1C, 8'h55, 4'h1, 2'h2);
		rd(16'hFE1C, 2'h2, 8'h00);
		wr(`IDX_SENSE_CFG_A, 8'h8F, 4'h0, 0);
		wr(`IDX_STATUS, 8'hFF, 4'h1, 0);
		rd(`IDX_STATUS, 0, 8'h00);
		wr(`IDX_SENSE_CFG_A, 8'h81, 4'h1, 0);
		wr(`IDX_SENSE_CFG_B, 8'h02, 4'h1, 0);
		rd(`IDX_SENSE_CFG_A, 0, 8'h81);
		chk({32'h0, chan_a_high_side_sense, chan_b_high_side_sense}, 34'h2);
		m = 1;
		for (c = 0; c < 10; c++)
		begin
			v = c < 5 ? VALS[c] : $random(seed) & 255;
			lvl_a <= v[11:0];
			lvl_b <= 12'($random(seed) & 127);
			m = v < 64 ? 1 : v >= 160 ? 0 : m;
			rd(`IDX_STATUS, 0, m ? 8'h3C : 8'h28);
		end
		wr(`IDX_SENSE_CFG_A, 8'h80, 4'h1, 0);
		lvl_a <= 12'h00A;
		rd(`IDX_STATUS, 0, 8'h28);
		wr(`IDX_SENSE_CFG_B, 8'h12, 4'h1, 0);
		chan_b_soft_start <= 1;
		rd(`IDX_STATUS, 0, 8'h20);
		chan_b_soft_start <= 0;
		rd(`IDX_STATUS, 0, 8'h28);
		wr(`IDX_OCP_THR_A, 8'h10, 4'h1, 0);
		for (c = 0; c < 4; c++)
		begin
			wr(`IDX_SENSE_CFG_A, 8'(c << 5), 4'h1, 0);
			lvl_a <= 12'h110;
			repeat (3) @(posedge sys_clk);
			lvl_a <= 12'h100;
			repeat (3) @(posedge sys_clk);
			lvl_a <= 12'h110;
			for (v = 0; v < 40 && chan_a_overcurrent_flag !== 1; v++)
				@(posedge sys_clk);
			chk(34'(v >= LIM[c] && v <= LIM[c] + 2), 34'h1);
			lvl_a <= 12'h100;
			repeat (3) @(posedge sys_clk);
			chk(34'(chan_a_overcurrent_flag), 34'h0);
		end
		wr(`IDX_OCP_THR_A, 8'hFF, 4'h1, 0);
		lvl_a <= 12'hFFF;
		rd(`IDX_STATUS, 0, 8'h28);
		// Output pins themselves, not only their status copies
		chk({28'h0, chan_a_overcurrent_flag, chan_b_overcurrent_flag, chan_a_light_load_flag,
			chan_b_light_load_flag, chan_a_light_load_mode, chan_b_light_load_mode}, 34'h05);
		tally_and_finish();
	end
endmodule : current_sense_ocp_lightload_detect_tb
`default_nettype wire
